//--- shared/phb_pkg.sv
// constants and types shared by the host bridge cpu side
package phb_pkg;
  // ****************************************
  // chip-select window areas
  // ****************************************
  localparam logic [13:0] AREA_SRAM_LAST = 14'h1fff;
  localparam logic [13:0] AREA_WIN_FIRST = 14'h2000;
  localparam logic [13:0] AREA_WIN_LAST = 14'h2fff;
  localparam logic [13:0] AREA_REG_FIRST = 14'h3000;
  localparam logic [13:0] AREA_REG_LAST = 14'h30ff;
  // ****************************************
  // register offsets inside the register area
  // ****************************************
  localparam logic [7:0] OFF_CFG_DATA = 8'h00;
  localparam logic [7:0] OFF_CFG_ADDR = 8'h04;
  localparam logic [7:0] OFF_CTRL1 = 8'h08;
  localparam logic [7:0] OFF_CTRL2 = 8'h0c;
  localparam logic [7:0] OFF_WIN_BASE = 8'h14;
  localparam logic [7:0] OFF_INT_STAT = 8'h18;
  localparam logic [7:0] OFF_INT_EN = 8'h1c;
  localparam logic [7:0] OFF_ERR_ADDR = 8'h20;
  localparam logic [7:0] OFF_DRAM_BASE = 8'h40;
  localparam logic [7:0] OFF_DRAM_RANGE = 8'h44;
  localparam logic [7:0] OFF_DRAM_CTL = 8'h48;
  localparam logic [7:0] OFF_SRAM_BASE = 8'h50;
  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [31:0] RST_CTRL1 = 32'h07000300;
  localparam logic [31:0] MSK_CTRL1 = 32'hff01023e;
  localparam logic [31:0] RST_CTRL2 = 32'h00000077;
  localparam logic [31:0] MSK_CTRL2 = 32'h00000077;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [31:0] MSK_WIN_BASE = 32'hfffff000;
  localparam logic [31:0] MSK_INT = 32'h00000d0f;
  localparam logic [31:0] MSK_DRAM_BASE = 32'hffff0000;
  localparam logic [31:0] RST_DRAM_RANGE = 32'h0000ffff;
  localparam logic [31:0] RST_DRAM_CTL = 32'h00070230;
  localparam logic [31:0] MSK_DRAM_CTL = 32'h0fff1333;
  localparam logic [31:0] MSK_SRAM_BASE = 32'hffffe000;
  localparam logic [31:0] MSK_CFG_ADDR = 32'hfffffffc;
  // ****************************************
  // field positions
  // ****************************************
  localparam int PARK_LSB = 24;
  localparam int PARK_MODE_BIT = 16;
  localparam int REQ_EN_BIT = 9;
  localparam int PCHK_BIT = 5;
  localparam int PCI_RUN_BIT = 4;
  localparam int SRAM_EN_BIT = 3;
  localparam int DRAM_EN_BIT = 2;
  localparam int MEM_EN_BIT = 1;
  localparam int WBUF_BUSY_BIT = 8;
  localparam int WBURST_LSB = 4;
  localparam int RBURST_LSB = 0;
  localparam int DRAM_WIDE_BIT = 12;
  localparam int PME_BIT = 11;
  localparam int SMMI_BIT = 10;
  localparam int INTA_BIT = 8;
  localparam int SERR_BIT = 3;
  localparam int PERR_BIT = 2;
  localparam int MABORT_BIT = 1;
  localparam int TABORT_BIT = 0;
  localparam logic [3:0] MAX_BURST = 4'h8;
  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [1:0] {
    PHB_IDLE = 2'b00,
    PHB_PCI = 2'b01
  } phb_cpu_state_t;
  typedef enum logic [1:0] {
    PHB_DR_IDLE = 2'b00,
    PHB_DR_REQ = 2'b01,
    PHB_DR_RUN = 2'b10
  } phb_dram_state_t;
endpackage : phb_pkg

//--- hdl/phb_park_timer.sv
// bus parking delay timer
`timescale 1ns/100ps
module phb_park_timer import phb_pkg::*; #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // bus state
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [W-1:0] delay,
  // result
  output logic park_now
);
  logic [W-1:0] cnt_reg;
  logic park_reg;
  wire bus_idle = frame_n & irdy_n;

  generate
    if (W < 1 || W > 16) begin : g_bad
      $error("phb_park_timer: width out of range");
    end
  endgenerate

  // count while frame and irdy are both high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      park_reg <= 1'b0;
    end else if (ce) begin
      if (!bus_idle) begin
        cnt_reg <= '0;
        park_reg <= 1'b0;
      end else if (cnt_reg >= delay) begin
        park_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
  assign park_now = park_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);
  property p_park_idle;
    !bus_idle |=> !park_reg;
  endproperty
  a_park_idle: assert property (p_park_idle)
    else $error("parking while bus busy");
endmodule : phb_park_timer

//--- hdl/phb_dram_req.sv
// memory-controller handshake and burst clamp for the dram area
`timescale 1ns/100ps
module phb_dram_req import phb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // request from the target side
  input wire logic start,
  input wire logic we,
  input wire logic [3:0] len,
  input wire logic [2:0] wr_limit,
  input wire logic [2:0] rd_limit,
  output logic busy,
  // memory controller
  output logic mem_bus_req,
  input wire logic mem_grant,
  output logic dram_go,
  output logic [3:0] dram_len,
  input wire logic dram_done
);
  phb_dram_state_t st_reg, st_next;
  logic go_reg;
  logic req_reg;
  logic [3:0] len_reg;
  wire [2:0] lim = we ? wr_limit : rd_limit;
  wire [3:0] cap = {1'b0, lim} + 4'h1;
  wire [3:0] clamp = (len > cap) ? cap : len;

  // next state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PHB_DR_IDLE: if (start) st_next = PHB_DR_REQ;
      PHB_DR_REQ: if (mem_grant) st_next = PHB_DR_RUN;
      PHB_DR_RUN: if (dram_done) st_next = PHB_DR_IDLE;
      default: st_next = PHB_DR_IDLE;
    endcase
  end

  // state and burst length
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= PHB_DR_IDLE;
      go_reg <= 1'b0;
      req_reg <= 1'b0;
      len_reg <= 4'h0;
    end else if (ce) begin
      st_reg <= st_next;
      req_reg <= (st_next == PHB_DR_REQ);
      go_reg <= (st_reg == PHB_DR_REQ) && mem_grant;
      if (start && st_reg == PHB_DR_IDLE) len_reg <= clamp;
    end
  end
  assign busy = (st_reg != PHB_DR_IDLE);
  assign mem_bus_req = req_reg; // request straight from a flop
  assign dram_go = go_reg;
  assign dram_len = len_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);
  sequence s_granted;
    mem_bus_req && mem_grant;
  endsequence
  property p_go_after_grant;
    dram_go |-> $past(mem_bus_req) && $past(mem_grant);
  endproperty
  a_go_after_grant: assert property (p_go_after_grant)
    else $error("dram driven without grant");
  property p_grant_go;
    s_granted |=> dram_go;
  endproperty
  a_grant_go: assert property (p_grant_go)
    else $error("grant not followed by dram start");
  property p_burst_cap;
    dram_go |-> dram_len <= MAX_BURST;
  endproperty
  a_burst_cap: assert property (p_burst_cap)
    else $error("dram burst above eight");
endmodule : phb_dram_req

//--- hdl/phb_bridge.sv
// cpu side of the host bridge: window decode, registers, pci cycles
`timescale 1ns/100ps
module phb_bridge import phb_pkg::*; #(
  parameter int SRAM_WORDS = 2048
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // cpu local bus
  input wire logic bridge_chip_select,
  input wire logic [13:0] cpu_addr,
  input wire logic cpu_we,
  input wire logic [3:0] cpu_be,
  input wire logic [31:0] cpu_wdata,
  output logic [31:0] cpu_rdata,
  output logic cpu_ack,
  output logic cpu_wait,
  // pci master cycles
  output logic pm_req,
  output logic pm_cfg,
  output logic pm_we,
  output logic [31:0] pm_addr,
  output logic [31:0] pm_wdata,
  input wire logic pm_done,
  input wire logic [31:0] pm_rdata,
  // pci target accesses
  input wire logic tg_req,
  input wire logic tg_we,
  input wire logic [31:0] tg_addr,
  input wire logic [31:0] tg_wdata,
  input wire logic [3:0] tg_len,
  output logic [31:0] tg_rdata,
  output logic tg_ack,
  output logic tg_refuse,
  // dram path
  output logic mem_bus_req,
  input wire logic mem_grant,
  output logic dram_go,
  output logic [3:0] dram_len,
  output logic dram_we,
  output logic [31:0] dram_addr,
  output logic dram_wide,
  input wire logic dram_done,
  // bus state and control
  input wire logic frame_n,
  input wire logic irdy_n,
  output logic parking_now,
  output logic parking_master_select,
  output logic pci_req_enable,
  output logic parity_check_en,
  output logic pci_bus_reset,
  // interrupt sources and errors
  input wire logic inta,
  input wire logic smmi,
  input wire logic pme,
  input wire logic err_serr,
  input wire logic err_perr,
  input wire logic err_mabort,
  input wire logic err_tabort,
  input wire logic [31:0] err_addr,
  output logic host_irq_zero,
  output logic host_irq_one
);
  localparam int AW = $clog2(SRAM_WORDS);
  generate
    if (SRAM_WORDS < 2 || SRAM_WORDS > 2048) begin : g_bad
      $error("phb_bridge: sram size out of range");
    end
  endgenerate

  function automatic logic in_area(input logic [13:0] a,
                                   input logic [13:0] lo,
                                   input logic [13:0] hi);
    in_area = (a >= lo) && (a <= hi);
  endfunction : in_area

  // ****************************************
  // registers
  // ****************************************
  phb_cpu_state_t st_reg;
  logic [31:0] cfg_addr_reg, ctrl1_reg, ctrl2_reg, win_base_reg;
  logic [31:0] int_en_reg, err_addr_reg, dr_base_reg, dr_range_reg;
  logic [31:0] dr_ctl_reg, sr_base_reg;
  logic [3:0] err_flag_reg;
  logic [31:0] sram_mem [SRAM_WORDS];
  logic [31:0] rdata_reg, tg_rdata_reg, pm_addr_reg, pm_wdata_reg;
  logic ack_reg, wait_reg, pm_req_reg, pm_cfg_reg, pm_we_reg;
  logic tg_ack_reg, tg_ref_reg, dr_we_reg, irq0_reg, irq1_reg;
  logic [31:0] dr_addr_reg;
  logic [4:0] ctl_out_reg;
  logic tg_busy, tg_dram_pend;

  // ****************************************
  // cpu decode
  // ****************************************
  wire cpu_take = bridge_chip_select && !ack_reg && st_reg == PHB_IDLE;
  wire a_sram = cpu_addr <= AREA_SRAM_LAST;
  wire a_win = in_area(cpu_addr, AREA_WIN_FIRST, AREA_WIN_LAST);
  wire a_reg = in_area(cpu_addr, AREA_REG_FIRST, AREA_REG_LAST);
  wire [7:0] off = cpu_addr[7:0];
  wire full = cpu_be == 4'hf;
  wire reg_wr = cpu_take && a_reg && cpu_we && full;
  wire rd_err = cpu_take && a_reg && !cpu_we && off == OFF_ERR_ADDR;
  wire cfg_go = cpu_take && a_reg && off == OFF_CFG_DATA;
  wire win_go = cpu_take && a_win && ctrl1_reg[MEM_EN_BIT];
  wire pci_go = cfg_go || win_go;
  wire may_req = ctrl1_reg[REQ_EN_BIT];
  wire [31:0] int_stat = {20'h0, pme, smmi, 1'b0, inta, 4'h0,
                          err_flag_reg};
  wire [31:0] wbusy = {23'h0, tg_busy && tg_we, 8'h0};
  wire [31:0] reg_rd =
    (off == OFF_CFG_ADDR) ? cfg_addr_reg :
    (off == OFF_CTRL1) ? ctrl1_reg :
    (off == OFF_CTRL2) ? (ctrl2_reg | wbusy) :
    (off == OFF_WIN_BASE) ? win_base_reg :
    (off == OFF_INT_STAT) ? int_stat :
    (off == OFF_INT_EN) ? int_en_reg :
    (off == OFF_ERR_ADDR) ? err_addr_reg :
    (off == OFF_DRAM_BASE) ? dr_base_reg :
    (off == OFF_DRAM_RANGE) ? dr_range_reg :
    (off == OFF_DRAM_CTL) ? dr_ctl_reg :
    (off == OFF_SRAM_BASE) ? sr_base_reg : RST_ZERO;

  // ****************************************
  // target decode
  // ****************************************
  wire dr_busy;
  wire tg_take = tg_req && !tg_busy && !tg_ack_reg && !tg_ref_reg;
  wire t_sram = (tg_addr & MSK_SRAM_BASE) == sr_base_reg;
  wire [15:0] dr_mask = ~dr_range_reg[31:16];
  wire t_dram = (tg_addr[31:16] & dr_mask) == (dr_base_reg[31:16] & dr_mask);
  wire len_ok = tg_len != 4'h0 && tg_len <= MAX_BURST;
  wire ok_sram = t_sram && ctrl1_reg[SRAM_EN_BIT] && len_ok;
  wire ok_dram = !t_sram && t_dram && ctrl1_reg[DRAM_EN_BIT]
                 && len_ok;
  wire tg_sram_go = tg_take && ok_sram;
  wire tg_dram_go = tg_take && ok_dram;
  wire tg_bad = tg_take && !ok_sram && !ok_dram;
  wire cpu_sram = cpu_take && a_sram && !tg_sram_go;
  wire [AW-1:0] sidx = tg_sram_go ? tg_addr[AW+1:2] : cpu_addr[AW+1:2];
  wire s_we = tg_sram_go ? tg_we : (cpu_sram && cpu_we && full);
  wire [31:0] s_wd = tg_sram_go ? tg_wdata : cpu_wdata;
  wire cpu_done = cpu_take && !pci_go && !(a_sram && tg_sram_go);
  assign tg_busy = dr_busy || tg_dram_pend;
  wire [31:0] pm_addr_next = cfg_go ? (cfg_addr_reg & MSK_CFG_ADDR)
    : {win_base_reg[31:12], cpu_addr[11:0]};

  // shared sram, target side served first
  always_ff @(posedge clk) begin
    if (ce) begin
      if (s_we) sram_mem[sidx] <= s_wd;
      rdata_reg <= a_sram ? sram_mem[sidx] : (a_reg ? reg_rd : RST_ZERO);
      if (pm_done && pm_req_reg) rdata_reg <= pm_rdata;
      tg_rdata_reg <= sram_mem[sidx];
    end
  end

  // cpu cycle sequencing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= PHB_IDLE;
      ack_reg <= 1'b0;
      wait_reg <= 1'b0;
      pm_req_reg <= 1'b0;
      pm_cfg_reg <= 1'b0;
      pm_we_reg <= 1'b0;
      pm_addr_reg <= RST_ZERO;
      pm_wdata_reg <= RST_ZERO;
    end else if (ce) begin
      ack_reg <= cpu_done || (st_reg == PHB_PCI && pm_req_reg && pm_done);
      if (pci_go) begin
        st_reg <= PHB_PCI;
        wait_reg <= 1'b1;
        pm_cfg_reg <= cfg_go;
        pm_we_reg <= cpu_we;
        pm_addr_reg <= pm_addr_next;
        pm_wdata_reg <= cpu_wdata;
      end else if (st_reg == PHB_PCI) begin
        if (!pm_req_reg && may_req) pm_req_reg <= 1'b1;
        if (pm_req_reg && pm_done) begin
          pm_req_reg <= 1'b0;
          wait_reg <= 1'b0;
          st_reg <= PHB_IDLE;
        end
      end
    end
  end

  // software registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_addr_reg <= RST_ZERO;
      ctrl1_reg <= RST_CTRL1;
      ctrl2_reg <= RST_CTRL2;
      win_base_reg <= RST_ZERO;
      int_en_reg <= RST_ZERO;
      dr_base_reg <= RST_ZERO;
      dr_range_reg <= RST_DRAM_RANGE;
      dr_ctl_reg <= RST_DRAM_CTL;
      sr_base_reg <= RST_ZERO;
    end else if (ce && reg_wr) begin
      case (off)
        OFF_CFG_ADDR: cfg_addr_reg <= cpu_wdata & MSK_CFG_ADDR;
        OFF_CTRL1: ctrl1_reg <= (cpu_wdata & MSK_CTRL1)
                                | (ctrl1_reg & ~MSK_CTRL1);
        OFF_CTRL2: ctrl2_reg <= cpu_wdata & MSK_CTRL2;
        OFF_WIN_BASE: win_base_reg <= cpu_wdata & MSK_WIN_BASE;
        OFF_INT_EN: int_en_reg <= cpu_wdata & MSK_INT;
        OFF_DRAM_BASE: dr_base_reg <= cpu_wdata & MSK_DRAM_BASE;
        OFF_DRAM_RANGE: dr_range_reg <= (cpu_wdata & MSK_DRAM_BASE)
                                        | RST_DRAM_RANGE;
        OFF_DRAM_CTL: dr_ctl_reg <= cpu_wdata & MSK_DRAM_CTL;
        OFF_SRAM_BASE: sr_base_reg <= cpu_wdata & MSK_SRAM_BASE;
        default: ;
      endcase
    end
  end

  // error flags: set wins over a write-one clear
  wire [3:0] err_in = {err_serr, err_perr, err_mabort, err_tabort};
  wire [3:0] err_clr = (reg_wr && off == OFF_INT_STAT) ?
                       cpu_wdata[3:0] : 4'h0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_flag_reg <= 4'h0;
      err_addr_reg <= RST_ZERO;
    end else if (ce) begin
      err_flag_reg <= (err_flag_reg & ~err_clr) | err_in;
      if (|err_in) err_addr_reg <= err_addr;
      else if (rd_err) err_addr_reg <= RST_ZERO;
    end
  end

  // target side answers and dram start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tg_ack_reg <= 1'b0;
      tg_ref_reg <= 1'b0;
      tg_dram_pend <= 1'b0;
      dr_we_reg <= 1'b0;
      dr_addr_reg <= RST_ZERO;
    end else if (ce) begin
      tg_ref_reg <= tg_bad;
      tg_ack_reg <= tg_sram_go || (tg_dram_pend && dram_done);
      if (tg_dram_go) begin
        tg_dram_pend <= 1'b1;
        dr_we_reg <= tg_we;
        dr_addr_reg <= tg_addr;
      end else if (dram_done) begin
        tg_dram_pend <= 1'b0;
      end
    end
  end

  // control and interrupt outputs
  wire [31:0] int_live = int_stat & int_en_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_out_reg <= 5'h0;
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
    end else if (ce) begin
      ctl_out_reg <= {ctrl1_reg[PARK_MODE_BIT], ctrl1_reg[REQ_EN_BIT],
                      ctrl1_reg[PCHK_BIT], !ctrl1_reg[PCI_RUN_BIT],
                      dr_ctl_reg[DRAM_WIDE_BIT]};
      irq0_reg <= |int_live;
      irq1_reg <= int_live[PME_BIT];
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  phb_park_timer #(
    .W(8)
  ) u_park (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .frame_n(frame_n),
    .irdy_n(irdy_n),
    .delay(ctrl1_reg[PARK_LSB+7:PARK_LSB]),
    .park_now(parking_now)
  );

  phb_dram_req u_dram (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .start(tg_dram_go),
    .we(tg_we),
    .len(tg_len),
    .wr_limit(ctrl2_reg[WBURST_LSB+2:WBURST_LSB]),
    .rd_limit(ctrl2_reg[RBURST_LSB+2:RBURST_LSB]),
    .busy(dr_busy),
    .mem_bus_req(mem_bus_req),
    .mem_grant(mem_grant),
    .dram_go(dram_go),
    .dram_len(dram_len),
    .dram_done(dram_done)
  );

  assign cpu_rdata = rdata_reg;
  assign cpu_ack = ack_reg;
  assign cpu_wait = wait_reg;
  assign pm_req = pm_req_reg;
  assign pm_cfg = pm_cfg_reg;
  assign pm_we = pm_we_reg;
  assign pm_addr = pm_addr_reg;
  assign pm_wdata = pm_wdata_reg;
  assign tg_rdata = tg_rdata_reg;
  assign tg_ack = tg_ack_reg;
  assign tg_refuse = tg_ref_reg;
  assign dram_we = dr_we_reg;
  assign dram_addr = dr_addr_reg;
  assign {parking_master_select, pci_req_enable, parity_check_en,
          pci_bus_reset, dram_wide} = ctl_out_reg;
  assign host_irq_zero = irq0_reg;
  assign host_irq_one = irq1_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);
  property p_cfg_cycle;
    cfg_go |=> pm_cfg && pm_addr == $past(cfg_addr_reg & MSK_CFG_ADDR);
  endproperty
  a_cfg_cycle: assert property (p_cfg_cycle)
    else $error("config cycle address wrong");
  property p_win_addr;
    win_go |=> !pm_cfg && pm_addr[31:12] == $past(win_base_reg[31:12]);
  endproperty
  a_win_addr: assert property (p_win_addr)
    else $error("window upper address wrong");
  property p_no_req;
    !may_req && !pm_req |=> !pm_req;
  endproperty
  a_no_req: assert property (p_no_req)
    else $error("pci request while disabled");
  property p_sram_refuse;
    tg_take && t_sram && !ctrl1_reg[SRAM_EN_BIT] |=> tg_refuse && !tg_ack;
  endproperty
  a_sram_refuse: assert property (p_sram_refuse)
    else $error("sram access not refused");
  property p_long_burst;
    tg_take && tg_len > MAX_BURST |=> tg_refuse;
  endproperty
  a_long_burst: assert property (p_long_burst)
    else $error("burst above eight accepted");
  property p_err_clear;
    rd_err && !(|err_in) |=> err_addr_reg == RST_ZERO;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error address not cleared by read");
  property p_irq_masked;
    int_en_reg == RST_ZERO && $past(int_en_reg) == RST_ZERO
      |-> !host_irq_zero && !host_irq_one;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt while all sources disabled");
  property p_reg_ack;
    cpu_take && a_reg && off != OFF_CFG_DATA |=> cpu_ack ##1 !cpu_ack;
  endproperty
  a_reg_ack: assert property (p_reg_ack)
    else $error("register access not answered in one cycle");
endmodule : phb_bridge

//--- test/phb_far_model.sv
// far-side model: pci target and memory controller
`timescale 1ns/100ps
module phb_far_model import phb_pkg::*; #(
  parameter logic [31:0] RD = 32'h5a3c96e1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pci target side
  input wire logic pm_req,
  output logic pm_done,
  output logic [31:0] pm_rdata,
  // memory controller side
  input wire logic mem_bus_req,
  output logic mem_grant,
  input wire logic dram_go,
  output logic dram_done
);
  logic [2:0] cnt;
  logic go_d;
  // data only valid with done, otherwise a changing pattern
  assign pm_rdata = pm_done ? RD : ~RD ^ {29'h0, cnt};
  // ****************
  // answers
  // ****************
  // target done three cycles into a request, grant follows request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {cnt, pm_done, mem_grant, go_d, dram_done} <= '0;
    end else begin
      pm_done <= pm_req && cnt == 3'h2;
      cnt <= (pm_req && !pm_done) ? cnt + 3'h1 : 3'h0;
      mem_grant <= mem_bus_req;
      go_d <= dram_go;
      dram_done <= go_d;
    end
  end
endmodule : phb_far_model

//--- test/phb_bridge_tb.sv
// self-checking bench for the host bridge cpu side
`timescale 1ns/100ps
module phb_bridge_tb import phb_pkg::*; ;
  localparam logic [31:0] FAR_RD = 32'h5a3c96e1;
  typedef struct {logic [13:0] a; logic w; logic [31:0] d, e;} phb_row_t;
  logic clk = 0, reset = 1, ce = 1, bridge_chip_select = 0, cpu_we = 0;
  logic tg_req = 0, tg_we = 0, frame_n = 1, irdy_n = 1;
  logic [13:0] cpu_addr = '0;
  logic [3:0] cpu_be = 4'hf, tg_len = 4'h1, err = '0, dram_len, c_len;
  logic [2:0] src = '0;
  logic [31:0] cpu_wdata = '0, tg_addr = '0, tg_wdata = '0, err_addr = '0;
  logic [31:0] cpu_rdata, pm_addr, pm_wdata, pm_rdata, tg_rdata, dram_addr;
  logic [31:0] rd, c_addr, c_wd;
  logic inta, smmi, pme, err_serr, err_perr, err_mabort, err_tabort;
  logic cpu_ack, cpu_wait, pm_req, pm_cfg, pm_we, pm_done, tg_ack;
  logic tg_refuse, mem_bus_req, mem_grant, dram_go, dram_we, dram_wide;
  logic dram_done, parking_now, parking_master_select, pci_req_enable;
  logic parity_check_en, pci_bus_reset, host_irq_zero, host_irq_one;
  logic c_cfg, c_we, c_dwe, c_wait;
  int err_count = 0, checks_done = 0, cyc = 0, npm = 0;
  phb_row_t rows [16] = '{'{14'h3008, '0, '0, 32'h07000300},
    '{14'h300c, '0, '0, 32'h77}, '{14'h3004, '0, '0, '0},
    '{14'h3018, '0, '0, '0}, '{14'h301c, '0, '0, '0},
    '{14'h3048, '0, '0, 32'h70230}, '{14'h3044, '0, '0, 32'hffff},
    '{14'h3010, '0, '0, '0}, '{14'h3100, '0, '0, '0},
    '{14'h3004, 1'h1, 32'h80000107, '0}, '{14'h3004, '0, '0, 32'h80000104},
    '{14'h3014, 1'h1, 32'habcde123, '0}, '{14'h3014, '0, '0, 32'habcde000},
    '{14'h0010, 1'h1, 32'hcafef00d, '0}, '{14'h0010, '0, '0, 32'hcafef00d},
    '{14'h2010, '0, '0, '0}};
  assign {pme, smmi, inta} = src;
  assign {err_serr, err_perr, err_mabort, err_tabort} = err;
  phb_bridge u_phb_bridge (.*);
  phb_far_model #(.RD(FAR_RD)) u_phb_far_model (.*);
  always #5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // capture what the design put on the pci and dram sides
  always @(posedge clk) begin
    if (pm_req === 1'b1 && pm_done === 1'b1) begin
      npm++;
      {c_addr, c_wd, c_cfg, c_we} = {pm_addr, pm_wdata, pm_cfg, pm_we};
      c_wait = cpu_wait;
    end
    if (dram_go === 1'b1) {c_len, c_dwe} = {dram_len, dram_we};
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic cpu(input logic [13:0] a, input logic w,
                     input logic [31:0] d);
    @(negedge clk);
    {bridge_chip_select, cpu_addr, cpu_we, cpu_wdata} = {1'b1, a, w, d};
    for (int i = 0; i < 50 && cpu_ack !== 1'b1; i++) @(posedge clk) #1;
    chk("cpu_ack", 1, cpu_ack);
    rd = cpu_rdata;
    @(posedge clk);
    @(negedge clk) bridge_chip_select = 1'b0;
  endtask : cpu
  task automatic tgt(input logic [31:0] a, input logic w,
                     input logic [3:0] l, input logic ok);
    @(negedge clk);
    {tg_req, tg_addr, tg_we, tg_len, tg_wdata} = {1'b1, a, w, l, ~a};
    for (int i = 0; i < 50 && tg_ack !== 1'b1 && tg_refuse !== 1'b1; i++)
      @(posedge clk) #1;
    chk("tg_ack", ok, tg_ack);
    chk("tg_refuse", !ok, tg_refuse);
    rd = tg_rdata;
    @(posedge clk);
    @(negedge clk) tg_req = 1'b0;
  endtask : tgt
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    foreach (rows[i]) begin
      cpu(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("row", rows[i].e, rd);
    end
    chk("pm_cycles", 0, npm);
    chk("req_en", 1, pci_req_enable);
    tgt(32'h10, 1'b0, 4'h1, 1'b0);
    tgt(32'h8000, 1'b1, 4'h4, 1'b0);
    cpu(14'h3008, 1'b1, 32'h0401021a);
    chk("park_mode", 1, parking_master_select);
    cpu(14'h3000, 1'b0, '0);
    chk("cfg_rd", FAR_RD, rd);
    chk("cfg_addr", 32'h80000104, c_addr);
    chk("cfg_kind", 1, c_cfg);
    chk("cpu_wait", 1, c_wait);
    cpu(14'h3000, 1'b1, 32'h12345678);
    chk("cfg_wd", 32'h12345678, c_wd);
    chk("cfg_we", 1, c_we);
    cpu(14'h2010, 1'b0, '0);
    chk("win_addr", 32'habcde010, c_addr);
    chk("win_kind", 0, c_cfg);
    cpu_be = 4'h3;
    cpu(14'h3014, 1'b1, '0);
    cpu_be = 4'hf;
    cpu(14'h3014, 1'b0, '0);
    chk("narrow_wr", 32'habcde000, rd);
    tgt(32'h10, 1'b0, 4'h1, 1'b1);
    chk("sram_rd", 32'hcafef00d, rd);
    cpu(14'h3008, 1'b1, 32'h0401021e);
    tgt(32'h8000, 1'b1, 4'h8, 1'b1);
    chk("wr_len", 8, c_len);
    chk("dram_addr", 32'h8000, dram_addr);
    tgt(32'h8000, 1'b0, 4'h9, 1'b0);
    cpu(14'h300c, 1'b1, 32'h10);
    tgt(32'h8000, 1'b1, 4'h8, 1'b1);
    chk("wr_clamp", 2, c_len);
    tgt(32'h8000, 1'b0, 4'h5, 1'b1);
    chk("rd_clamp", 1, c_len);
    chk("rd_kind", 0, c_dwe);
    cpu(14'h3048, 1'b1, 32'h71230);
    chk("wide", 1, dram_wide);
    src = 3'h1;
    cpu(14'h3018, 1'b1, 32'hd00);
    chk("masked", 0, host_irq_zero);
    cpu(14'h301c, 1'b1, 32'hd0f);
    for (int k = 0; k < 3; k++) begin
      src = 3'h1 << k;
      cpu(14'h3018, 1'b1, 32'hd00);
      cpu(14'h3018, 1'b0, '0);
      chk("src", 32'h1 << (k == 0 ? 8 : k + 9), rd);
      chk("irq0", 1, host_irq_zero);
      chk("irq1", k == 2, host_irq_one);
    end
    src = '0;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk) {err, err_addr} = {4'h1 << k, 32'h1000 + k};
      @(negedge clk) err = '0;
      cpu(14'h3018, 1'b0, '0);
      chk("err_flag", 32'h1 << k, rd);
      cpu(14'h3020, 1'b0, '0);
      chk("err_addr", 32'h1000 + k, rd);
      cpu(14'h3018, 1'b1, 32'h1 << k);
    end
    cpu(14'h3020, 1'b0, '0);
    chk("err_clr", 0, rd);
    @(negedge clk) frame_n = 1'b0;
    @(negedge clk) frame_n = 1'b1;
    @(negedge clk) chk("park_off", 0, parking_now);
    repeat (8) @(negedge clk);
    chk("park_on", 1, parking_now);
    test_done();
  end
endmodule : phb_bridge_tb
